// [hw/shr_host.sv]
// host controller driving a serial register port, ahb-lite slave
//
// How it works
// - sel pin high: three wires, low: two
// - cd high: byte is a control byte
// - cd low after read choice: read mode
// - cd low after write choice; data before rise
// - standby request bit one requests, zero cancels
// - in standby only control write, flag read
// - no reads while standby is pending
// - single device: chip select held low (here cs_n follows the control register select bit)
// - events may be polled via flag register
// - two-wire: host releases line during reads
// - never select an unassigned register address
`timescale 1ns/1ps
`include "shr_defs.svh"
module shr_host (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output shr_pkg::shr_pins_t pins,
  output logic sck_o,
  output logic sd_o,
  output logic sd_oe_n,
  input wire logic sd_i,
  input wire logic so_i,
  input wire logic irq_i
);

  // address and read choice are legal device registers
  function automatic logic addr_ok(input shr_pkg::shr_tgt_t t);
    if (t.rd) begin
      addr_ok = (t.addr <= `SHR_R_RLAST) || (t.addr == `SHR_R_BUF);
    end else begin
      addr_ok = (t.addr <= `SHR_R_WLAST) || (t.addr == `SHR_R_BUF);
    end
  endfunction : addr_ok

  // the only accesses a sleeping device answers
  function automatic logic stby_ok(input shr_pkg::shr_tgt_t t);
    stby_ok = (!t.rd && t.addr == `SHR_R_CTL) ||
              (t.rd && t.addr == `SHR_R_FLAG);
  endfunction : stby_ok

  // bus capture
  logic wr_q;
  logic [7:0] waddr_q;
  logic [`SHR_CTRL_W-1:0] ctrl_q;
  logic err_q;
  logic stby_q;
  logic [7:0] rdat_q;
  shr_pkg::shr_tgt_t tgt_q;
  shr_pkg::shr_state_t state_q;
  logic [7:0] gap_q;
  logic start_q;
  logic [7:0] byte_q;
  logic [7:0] wdat_q;

  // input synchronisers: so, sd, irq
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [2:0] pin_in;
  assign pin_in = {irq_i, sd_i, so_i};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta_q[gi] <= 1'b1;
          sync_q[gi] <= 1'b1;
        end else begin
          meta_q[gi] <= pin_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  logic so_s;
  logic sd_s;
  logic irq_s;
  assign so_s = sync_q[0];
  assign sd_s = sync_q[1];
  assign irq_s = sync_q[2];

  // address phase decode
  logic addr_ph;
  assign addr_ph = hsel && htrans[1] && hready;

  logic wire3;
  logic dev_run;
  assign wire3 = ctrl_q[`SHR_CTRL_WIRE3];
  assign dev_run = ctrl_q[`SHR_CTRL_RUN];

  logic busy;
  assign busy = (state_q != shr_pkg::S_IDLE);

  logic [31:0] stat_word;
  // irq pin only polled through status, no interrupt logic
  assign stat_word = {28'h000_0000, irq_s, stby_q, err_q, busy};

  logic [31:0] rd_mux;
  assign rd_mux = (haddr[7:0] == `SHR_A_CTRL) ?
                    {29'h0000_0000, ctrl_q} :
                  (haddr[7:0] == `SHR_A_STAT) ? stat_word :
                  (haddr[7:0] == `SHR_A_RDAT) ?
                    {24'h00_0000, rdat_q} : 32'h0000_0000;

  // data phase writes
  logic wr_ctrl;
  logic wr_cmd;
  logic wr_stat;
  assign wr_ctrl = wr_q && (waddr_q == `SHR_A_CTRL);
  assign wr_cmd = wr_q && (waddr_q == `SHR_A_CMD);
  assign wr_stat = wr_q && (waddr_q == `SHR_A_STAT);

  // a data-only command keeps the last chosen register
  shr_pkg::shr_tgt_t cmd_tgt;
  assign cmd_tgt = hwdata[`SHR_CMD_DONLY] ? tgt_q :
                   '{addr: hwdata[`SHR_CMD_ADDR],
                     rd: hwdata[`SHR_CMD_RD]};

  logic cmd_ok;
  assign cmd_ok = !busy && dev_run && addr_ok(cmd_tgt) &&
                  (!stby_q || stby_ok(cmd_tgt));

  logic go;
  logic cmd_bad;
  assign go = wr_cmd && cmd_ok;
  assign cmd_bad = wr_cmd && !cmd_ok;

  logic [7:0] ctl_byte;
  assign ctl_byte = {tgt_q.rd, 3'h0, tgt_q.addr};

  logic sh_busy;
  logic sh_done;
  logic sh_din;
  logic [7:0] sh_rx;
  assign sh_din = wire3 ? so_s : sd_s;

  shr_shift u_shift (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(start_q),
    .tx_byte(byte_q),
    .din(sh_din),
    .sck(sck_o),
    .dout(sd_o),
    .busy(sh_busy),
    .done(sh_done),
    .rx_byte(sh_rx)
  );

  logic gap_end;
  assign gap_end = (gap_q == 8'h00) && !start_q && !sh_busy;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      waddr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      // zero wait states: read data is fetched at the address phase
      wr_q <= addr_ph && hwrite;
      waddr_q <= haddr[7:0];
      if (addr_ph && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `SHR_CTRL_RST;
      err_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= hwdata[`SHR_CTRL_W-1:0];
      end
      // a refused command in the clear cycle still sets the flag
      if (cmd_bad) begin
        err_q <= 1'b1;
      end else if (wr_stat && hwdata[`SHR_ST_ERR]) begin
        err_q <= 1'b0;
      end
    end
  end

  // sel is updated only while idle so it never moves mid-byte; rst_n and cs_n follow the control register one edge later in any state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins <= '{sel: 1'b1, cs_n: 1'b1, cd: 1'b0, rst_n: 1'b0};
    end else begin
      pins.rst_n <= dev_run;
      pins.cs_n <= !ctrl_q[`SHR_CTRL_CSEL];
      if (!busy) begin
        pins.sel <= wire3;
      end
      if (state_q == shr_pkg::S_CSET) begin
        pins.cd <= 1'b1;
      end else if (state_q == shr_pkg::S_DSET) begin
        pins.cd <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= shr_pkg::S_IDLE;
      tgt_q <= '{addr: `SHR_R_CTL, rd: 1'b0};
      stby_q <= 1'b1;
      gap_q <= 8'h00;
      start_q <= 1'b0;
      byte_q <= 8'h00;
      wdat_q <= 8'h00;
      rdat_q <= 8'h00;
      sd_oe_n <= 1'b1;
    end else begin
      start_q <= 1'b0;
      if (!dev_run) begin
        // device in hardware reset: sleeps, target back to 0
        tgt_q <= '{addr: `SHR_R_CTL, rd: 1'b0};
        stby_q <= 1'b1;
      end
      unique case (state_q)
        shr_pkg::S_IDLE: begin
          if (go) begin
            tgt_q <= cmd_tgt;
            wdat_q <= hwdata[`SHR_CMD_WDATA];
            gap_q <= 8'(`SHR_HALF_CYC - 1);
            state_q <= hwdata[`SHR_CMD_DONLY] ?
                       shr_pkg::S_DSET : shr_pkg::S_CSET;
          end
        end
        shr_pkg::S_CSET: begin
          sd_oe_n <= 1'b0;
          if (gap_q != 8'h00) begin
            gap_q <= gap_q - 8'h01;
          end else begin
            byte_q <= ctl_byte;
            start_q <= 1'b1;
            state_q <= shr_pkg::S_CSHF;
          end
        end
        shr_pkg::S_CSHF: begin
          if (sh_done) begin
            gap_q <= 8'(`SHR_HALF_CYC - 1);
            state_q <= shr_pkg::S_DSET;
          end
        end
        shr_pkg::S_DSET: begin
          // release the shared line before the device drives it
          sd_oe_n <= tgt_q.rd && !wire3;
          if (gap_q != 8'h00) begin
            gap_q <= gap_q - 8'h01;
          end else if (gap_end) begin
            byte_q <= tgt_q.rd ? `SHR_RD_FILL : wdat_q;
            start_q <= 1'b1;
            state_q <= shr_pkg::S_DSHF;
          end
        end
        shr_pkg::S_DSHF: begin
          if (sh_done) begin
            state_q <= shr_pkg::S_IDLE;
            if (tgt_q.rd) begin
              rdat_q <= sh_rx;
            end else if (tgt_q.addr == `SHR_R_CTL) begin
              stby_q <= wdat_q[`SHR_CTL_STBY];
            end
          end
        end
      endcase
    end
  end

endmodule : shr_host

// [pkg/shr_defs.svh]
// constants for the serial register port host controller
`ifndef SHR_DEFS_SVH
`define SHR_DEFS_SVH

// bus offsets of the controller's own registers
`define SHR_A_CTRL 8'h00
`define SHR_A_CMD 8'h04
`define SHR_A_STAT 8'h08
`define SHR_A_RDAT 8'h0C

// control register bits
`define SHR_CTRL_WIRE3 0
`define SHR_CTRL_CSEL 1
`define SHR_CTRL_RUN 2
`define SHR_CTRL_W 3
`define SHR_CTRL_RST 3'h3

// command register fields
`define SHR_CMD_ADDR 3:0
`define SHR_CMD_RD 4
`define SHR_CMD_DONLY 5
`define SHR_CMD_WDATA 15:8

// status register bits
`define SHR_ST_BUSY 0
`define SHR_ST_ERR 1
`define SHR_ST_STBY 2
`define SHR_ST_IRQ 3

// device register addresses, device bit positions and read fill byte
`define SHR_R_CTL 4'h0
`define SHR_R_FLAG 4'h1
`define SHR_R_BUF 4'hE
`define SHR_R_WLAST 4'h6
`define SHR_R_RLAST 4'h8
`define SHR_CTL_STBY 0
`define SHR_CB_RD 7
`define SHR_RD_FILL 8'hFF

// serial clock timing
`define SHR_CLK_NS 50
`define SHR_HALF_NS 1000
`define SHR_HALF_CYC ((`SHR_HALF_NS + `SHR_CLK_NS - 1) / `SHR_CLK_NS)
`define SHR_BITS 3'h7

`endif

// [pkg/shr_pkg.sv]
// types for the serial register port host controller
package shr_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic rd;
  } shr_tgt_t;

  typedef struct packed {
    logic sel;
    logic cs_n;
    logic cd;
    logic rst_n;
  } shr_pins_t;

  typedef enum logic [2:0] {
    S_IDLE,
    S_CSET,
    S_CSHF,
    S_DSET,
    S_DSHF
  } shr_state_t;

endpackage : shr_pkg

// [hw/shr_shift.sv]
// one byte shifter: serial clock, lsb first out and in
`timescale 1ns/1ps
`include "shr_defs.svh"
module shr_shift (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic [7:0] tx_byte,
  input wire logic din,
  output logic sck,
  output logic dout,
  output logic busy,
  output logic done,
  output logic [7:0] rx_byte
);

  logic [7:0] cnt_q;
  logic [2:0] bit_q;
  logic hi_q;
  logic [7:0] tx_q;
  logic cnt_end;

  assign cnt_end = (cnt_q == 8'h00);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck <= 1'b1;
      dout <= 1'b1;
      busy <= 1'b0;
      done <= 1'b0;
      rx_byte <= 8'h00;
      cnt_q <= 8'h00;
      bit_q <= 3'h0;
      hi_q <= 1'b0;
      tx_q <= 8'h00;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        if (start) begin
          // falling edge: device shifts out, we present a new bit
          busy <= 1'b1;
          sck <= 1'b0;
          dout <= tx_byte[0];
          tx_q <= tx_byte;
          bit_q <= 3'h0;
          hi_q <= 1'b0;
          cnt_q <= 8'(`SHR_HALF_CYC - 1);
        end
      end else if (!cnt_end) begin
        cnt_q <= cnt_q - 8'h01;
      end else if (!hi_q) begin
        sck <= 1'b1; // device samples here
        hi_q <= 1'b1;
        cnt_q <= 8'(`SHR_HALF_CYC - 1);
      end else begin
        // late in the high phase so synced read data has settled
        rx_byte <= {din, rx_byte[7:1]};
        if (bit_q == `SHR_BITS) begin
          busy <= 1'b0; // always whole bytes of eight clocks
          done <= 1'b1;
        end else begin
          bit_q <= bit_q + 3'h1;
          sck <= 1'b0;
          dout <= tx_q[1];
          tx_q <= {1'b1, tx_q[7:1]};
          hi_q <= 1'b0;
          cnt_q <= 8'(`SHR_HALF_CYC - 1);
        end
      end
    end
  end

endmodule : shr_shift

// [tb/shr_host_asserts.sv]
// checker on the serial pins of the host controller
`timescale 1ns/1ps
module shr_host_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire shr_pkg::shr_pins_t pins,
  input wire logic sck_o,
  input wire logic sd_o
);
  logic [2:0] falls_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // wraps every byte, so it reads zero between whole bytes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      falls_q <= 3'h0;
    end else if ($fell(sck_o)) begin
      falls_q <= falls_q + 3'h1;
    end
  end
  a_low_phase:
    assert property ($fell(sck_o) |=> !sck_o [*7])
    else $error("serial clock low phase too short");
  a_high_phase:
    assert property ($rose(sck_o) |=> sck_o [*7])
    else $error("serial clock high phase too short");
  a_cd_in_byte:
    assert property (!sck_o |-> $stable(pins.cd))
    else $error("command line moved inside a byte");
  a_eight_clocks:
    assert property ($changed(pins.cd) |-> falls_q == 3'h0)
    else $error("byte not eight clocks long");
  a_cd_lead:
    assert property ($rose(pins.cd) |=> sck_o [*8])
    else $error("clock started too soon after command");
  a_data_stable:
    assert property ($rose(sck_o) |-> $stable(sd_o))
    else $error("data changed at rising clock");
  a_quiet_reset:
    assert property (!pins.rst_n |-> sck_o)
    else $error("clocking a device held in reset");
  a_selected:
    assert property (!sck_o |-> !pins.cs_n)
    else $error("clocking without chip select");
  a_sel_idle:
    assert property ($changed(pins.sel) |-> sck_o && $stable(sck_o))
    else $error("wire mode changed while clocking");
  c_ctrl_byte: cover property ($rose(pins.cd));
  c_two_wire: cover property (!pins.sel && $fell(sck_o));
  c_dev_run: cover property ($rose(pins.rst_n));
endmodule : shr_host_asserts

bind shr_host shr_host_asserts u_chk (.hclk(hclk), .hresetn(hresetn),
  .pins(pins), .sck_o(sck_o), .sd_o(sd_o));

// [tb/shr_dev_model.sv]
// behavioural model of the serial register port device
`timescale 1ns/1ps
module shr_dev_model (
  input wire shr_pkg::shr_pins_t pins,
  input wire logic sck,
  input wire logic sd_o,
  input wire logic sd_oe_n,
  output logic sd_i,
  output logic so_i,
  output logic irq_i
);
  logic [7:0] mem [16];
  logic [7:0] sh;
  logic [7:0] rv;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic standby_flag = 1'b1;
  logic dq = 1'b1;
  int n = 0;
  wire act = pins.rst_n && !pins.cs_n;
  wire rmode = act && rd && !pins.cd;
  wire [7:0] flag = {6'h0, standby_flag, irq_i};
  assign irq_i = 1'b0;
  // released shared line floats up to the pull-up
  assign sd_i = !sd_oe_n ? sd_o : (rmode && !pins.sel) ? dq : 1'b1;
  // floating output shows the inverse of the last bit
  assign so_i = (!act || !pins.sel) ? ~dq : rmode ? dq : 1'b1;
  always @(pins.rst_n or pins.cd) begin
    n = 0;
    if (!pins.rst_n) begin
      addr = 4'h0;
      rd = 1'b0;
      standby_flag = 1'b1;
    end
  end
  always @(negedge sck) if (rmode) begin
    rv = (n == 0) ? ((addr == 4'h1) ? flag : mem[addr] ^ 8'h3C) : rv >> 1;
    dq = rv[0];
  end
  // slow link clock leaves room for the device's input sync
  always @(posedge sck) if (act) begin
    sh = {sd_i, sh[7:1]};
    n = n + 1;
    if (n == 8) begin
      n = 0;
      if (pins.cd) begin
        {rd, addr} = {sh[7], sh[3:0]};
      end else if (!rd && (!standby_flag || addr == 4'h0)) begin
        mem[addr] = sh;
        if (addr == 4'h0) standby_flag = sh[0];
      end
    end
  end
endmodule : shr_dev_model

// [tb/tb_serial_host_register_port.sv]
// testbench of the serial register port host controller
`timescale 1ns/1ps
`include "shr_defs.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
  $display("wrong value at %0t: %h not %h", $time, a, e); end end
module tb_serial_host_register_port;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic hreadyout, hresp, sck_o, sd_o, sd_oe_n, sd_i, so_i, irq_i;
  shr_pkg::shr_pins_t pins;
  int failures = 0;
  int tests_run = 0;
  shr_host dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pins(pins), .sck_o(sck_o), .sd_o(sd_o),
    .sd_oe_n(sd_oe_n), .sd_i(sd_i), .so_i(so_i), .irq_i(irq_i));
  shr_dev_model dev (.pins(pins), .sck(sck_o), .sd_o(sd_o),
    .sd_oe_n(sd_oe_n), .sd_i(sd_i), .so_i(so_i), .irq_i(irq_i));
  initial begin
    forever #25 hclk = ~hclk;
  end
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    r = hrdata;
  endtask : bus
  // leaves the final status word in r
  task automatic cmd(input logic [3:0] a, input logic [1:0] m,
      input logic [7:0] d);
    bus(1'b1, `SHR_A_CMD, {16'h0, d, 2'h0, m, a});
    r = 32'h1;
    for (int i = 0; i < 4000 && r[0]; i++) bus(1'b0, `SHR_A_STAT, 32'h0);
    // a poll that never sees idle counts as a mismatch
    if (r[0]) failures++;
  endtask : cmd
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (60000) @(posedge hclk);
    failures++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, `SHR_A_CTRL, 32'h0);
    `CHK(r, 32'h3)
    `CHK(pins.rst_n, 1'b0)
    cmd(4'h2, 2'h0, 8'h11);
    `CHK(r, 32'h6)
    bus(1'b1, `SHR_A_STAT, 32'h2);
    bus(1'b1, `SHR_A_CTRL, 32'h7);
    cmd(4'h0, 2'h2, 8'h00);
    `CHK(dev.standby_flag, 1'b0)
    `CHK(r, 32'h0)
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, `SHR_A_CTRL, {29'h0, 2'h3, m[0]});
      // sel follows the control register one edge later
      repeat (2) @(posedge hclk);
      `CHK(pins.sel, m[0])
      cmd(4'h2, 2'h0, 8'hA5 + m[7:0]);
      `CHK(dev.mem[2], 8'hA5 + m[7:0])
      cmd(4'h2, 2'h1, 8'h00);
      bus(1'b0, `SHR_A_RDAT, 32'h0);
      `CHK(r[7:0], (8'hA5 + m[7:0]) ^ 8'h3C)
    end
    cmd(4'h7, 2'h0, 8'h00);
    `CHK(r, 32'h2)
    bus(1'b1, `SHR_A_STAT, 32'h2);
    cmd(4'h0, 2'h0, 8'h01);
    `CHK(dev.standby_flag, 1'b1)
    `CHK(r, 32'h4)
    cmd(4'h2, 2'h1, 8'h00);
    `CHK(r, 32'h6)
    bus(1'b1, `SHR_A_STAT, 32'h2);
    cmd(4'h1, 2'h1, 8'h00);
    bus(1'b0, `SHR_A_RDAT, 32'h0);
    `CHK(r, 32'h2)
    bus(1'b0, 8'h40, 32'h0);
    `CHK(r, 32'h0)
    `CHK(hresp, 1'b0)
    summarize();
  end
endmodule : tb_serial_host_register_port
